// [hw/pcsw_link_if.sv]
// Carrier between the serial receiver and the switch core
`timescale 1ns/10ps
interface pcsw_link_if;
	logic       link_en;     // Core allows new words
	logic [8:0] word;        // Latched control word
	logic       word_stb;    // One-cycle pulse when word updates

	modport rx   (input link_en, output word, output word_stb);
	modport core (output link_en, input word, input word_stb);
endinterface : pcsw_link_if

// [hw/pcsw_pkg.sv]
// Shared constants of the dual-slot card power switch control block
package pcsw_pkg;
	// Control word layout
	localparam int WORD_W          = 9;             // Bits in one control word
	localparam int BIT_A_PROG_HI   = 0;             // slot_a_prog_high_select
	localparam int BIT_A_PROG_LO   = 1;             // Slot A follow-card bit
	localparam int BIT_A_LOW_RAIL  = 2;             // slot_a_low_rail_bit
	localparam int BIT_A_HIGH_RAIL = 3;             // slot_a_high_rail_bit
	localparam int BIT_B_PROG_HI   = 4;             // slot_b_prog_high_select
	localparam int BIT_B_PROG_LO   = 5;             // Slot B follow-card bit
	localparam int BIT_B_HIGH_RAIL = 6;             // slot_b_high_rail_bit
	localparam int BIT_B_LOW_RAIL  = 7;             // slot_b_low_rail_bit
	localparam int BIT_POWER_DOWN  = 8;             // power_down_bit_n
	localparam logic [8:0] WORD_RESET = 9'h000;     // Power-down after reset

	// Output level codes for each supply
	localparam logic [2:0] LVL_FLOAT = 3'h0;        // All switches open
	localparam logic [2:0] LVL_GND   = 3'h1;        // Ground switch closed
	localparam logic [2:0] LVL_3V3   = 3'h2;        // 3.3 V switch closed
	localparam logic [2:0] LVL_5V    = 3'h3;        // 5 V switch closed
	localparam logic [2:0] LVL_12V   = 3'h4;        // 12 V switch closed

	// Supply index order
	localparam int SUP_A_CARD = 0;
	localparam int SUP_A_PROG = 1;
	localparam int SUP_B_CARD = 2;
	localparam int SUP_B_PROG = 3;
	localparam int NUM_SUP    = 4;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL    = 8'h00;     // Control
	localparam logic [7:0] OFF_WORD    = 8'h04;     // Applied word, read only
	localparam logic [7:0] OFF_STAT    = 8'h08;     // Live state, read only
	localparam logic [7:0] OFF_IRQ_STS = 8'h0c;     // Sticky events, read only
	localparam logic [7:0] OFF_IRQ_CLR = 8'h10;     // Write one to clear
	localparam logic [7:0] OFF_IRQ_EN  = 8'h14;     // Interrupt enables

	// Field positions
	localparam int CTRL_LINK_EN  = 0;               // Accept serial words
	localparam int STAT_OVERTEMP = 4;
	localparam int STAT_LATCHOFF = 5;
	localparam int STAT_LOWPOWER = 6;
	localparam int STAT_RAIL5    = 7;
	localparam int EV_WORD       = 0;               // Word applied
	localparam int EV_OVC        = 1;               // Overcurrent began
	localparam int EV_OT         = 2;               // Over-temperature began
	localparam int EV_LATCH      = 3;               // Latch-off entered
	localparam int NUM_EV        = 4;

	// Reset values
	localparam logic       CTRL_RESET   = 1'b1;
	localparam logic [3:0] IRQ_EN_RESET = 4'h0;
endpackage : pcsw_pkg

// [hw/pcsw_serial_rx.sv]
// Three-wire serial receiver: shifts on rising link clock edges, applies on latch
`timescale 1ns/10ps
module pcsw_serial_rx (
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	input  wire logic link_clock_in,
	input  wire logic link_data_in,
	input  wire logic link_latch_in,
	pcsw_link_if.rx   link
);
	logic [2:0] s1_r, s2_r;               // Two-stage synchroniser
	logic       clk_d_r, latch_d_r;       // Previous synced levels
	logic [8:0] shift_r;                  // Shift register, never seen outside
	logic [8:0] word_r;                   // Latched word
	logic       stb_r;

	// Edge detectors read only the second stage
	wire clk_rise   = s2_r[0] & ~clk_d_r;
	wire latch_rise = s2_r[2] & ~latch_d_r;
	wire [8:0] shift_nxt = {shift_r[7:0], s2_r[1]};

	// Synchronise pins; pins come from the controller's domain
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s1_r      <= 3'h0;
			s2_r      <= 3'h0;
			clk_d_r   <= 1'b0;
			latch_d_r <= 1'b0;
		end else begin
			s1_r      <= {link_latch_in, link_data_in, link_clock_in};
			s2_r      <= s1_r;
			clk_d_r   <= s2_r[0];
			latch_d_r <= s2_r[2];
		end
	end

	// Shift first bit sent ends up as bit 8
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			shift_r <= pcsw_pkg::WORD_RESET;
		end else if (clk_rise) begin
			shift_r <= shift_nxt; // R12
		end
	end

	// Whole word takes effect only on latch, so partial shifts stay hidden
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			word_r <= pcsw_pkg::WORD_RESET;
			stb_r  <= 1'b0;
		end else begin
			stb_r <= latch_rise & link.link_en;
			if (latch_rise && link.link_en) begin
				word_r <= shift_r; // R14
			end
		end
	end

	assign link.word     = word_r;
	assign link.word_stb = stb_r;

	property p_word_on_latch;
		@(posedge clk_in) disable iff (!rst_b_in)
		(word_r != $past(word_r)) |-> $past(latch_rise) && $past(link.link_en);
	endproperty
	a_word_on_latch: assert property (p_word_on_latch) // R14
		else $error("control word changed without a latch edge");
endmodule : pcsw_serial_rx

// [hw/pcsw_top.sv]
// Dual-slot card power switch control: decode, protection, APB registers
//
// Summary of operation
// R1: Slot A program supply from bits 0,1
// R2: Slot B program supply from bits 4,5
// R3: Slot A card supply from bits 3,2
// R4: Slot B card supply from bits 6,7
// R5: Power-down bit low floats all, low power
// R6: Follow setting copies same slot card level
// R7: Overcurrent flag low on any overcurrent
// R8: Overcurrent limits only the affected output
// R9: Overcurrent limits, never switches off
// R10: Over-temperature floats all until it clears
// R11: Below-ground latches off until power cycle
// R12: Control word arrives over serial link
// R13: Without 5 V only 3.3 V delivered
// R14: Word applies only once fully latched
`timescale 1ns/10ps
module pcsw_top (
	input  wire logic        REF_CLK_IN,
	input  wire logic        RST_B_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [7:0]  PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	input  wire logic        LINK_CLOCK_IN,
	input  wire logic        LINK_DATA_IN,
	input  wire logic        LINK_LATCH_IN,
	input  wire logic [3:0]  OVERCURRENT_IN,
	input  wire logic        OVERTEMP_IN,
	input  wire logic [3:0]  BELOW_GROUND_IN,
	input  wire logic        RAIL_5V_PRESENT_IN,
	output logic      [2:0]  SLOT_A_CARD_SUPPLY_OUT,
	output logic      [2:0]  SLOT_A_PROG_SUPPLY_OUT,
	output logic      [2:0]  SLOT_B_CARD_SUPPLY_OUT,
	output logic      [2:0]  SLOT_B_PROG_SUPPLY_OUT,
	output logic      [3:0]  CURRENT_LIMIT_OUT,
	output logic             OVERCURRENT_FLAG_N_OUT,
	output logic             LOW_POWER_OUT,
	output logic             IRQ_OUT
);
	pcsw_link_if link ();                  // Receiver to core

	logic [9:0]  sen_s1_r, sen_s2_r;       // Sensor synchroniser
	logic        ctrl_r;                   // Link enable
	logic        latch_off_r;              // Sticky until reset
	logic        ot_d_r, ovc_d_r;          // Edge history for events
	logic [3:0]  irq_sts_r, irq_en_r;
	logic [2:0]  lvl_r [4];                // Registered output levels
	logic [3:0]  limit_r;
	logic        ovc_n_r, low_pwr_r, irq_r;
	logic [31:0] prdata_r;
	logic        pready_r, pslverr_r;

	pcsw_serial_rx u_rx (
		.clk_in        (REF_CLK_IN),
		.rst_b_in      (RST_B_IN),
		.link_clock_in (LINK_CLOCK_IN),
		.link_data_in  (LINK_DATA_IN),
		.link_latch_in (LINK_LATCH_IN),
		.link          (link.rx)
	);
	assign link.link_en = ctrl_r;

	// Synced sensor views; second stage only
	wire [3:0] ovc_s   = sen_s2_r[3:0];
	wire       ot_s    = sen_s2_r[4];
	wire [3:0] bg_s    = sen_s2_r[8:5];
	wire       rail5_s = sen_s2_r[9];
	wire [8:0] w       = link.word;

	// Card supply code: (high rail, low rail) 01 gives 3.3 V, 10 gives 5 V
	function automatic logic [2:0] card_lvl(input logic hi, input logic lo,
	                                        input logic rail5);
		logic [2:0] l;
		l = pcsw_pkg::LVL_GND;             // 00 and 11 close the ground switch
		if (!hi && lo) begin
			l = pcsw_pkg::LVL_3V3;
		end else if (hi && !lo) begin
			l = rail5 ? pcsw_pkg::LVL_5V : pcsw_pkg::LVL_FLOAT; // R13
		end
		return l;
	endfunction : card_lvl

	// Program supply code: 00 ground, 01 follow card, 10 12 V, 11 float
	function automatic logic [2:0] prog_lvl(input logic hi, input logic lo,
	                                        input logic [2:0] card,
	                                        input logic rail5);
		logic [2:0] l;
		l = pcsw_pkg::LVL_FLOAT;
		case ({hi, lo})
			2'b00: l = pcsw_pkg::LVL_GND;
			2'b01: l = card; // R6
			2'b10: l = rail5 ? pcsw_pkg::LVL_12V : pcsw_pkg::LVL_FLOAT; // R13
			default: l = pcsw_pkg::LVL_FLOAT;
		endcase
		return l;
	endfunction : prog_lvl

	// Decode; any disable condition opens every switch
	wire run_ok = w[pcsw_pkg::BIT_POWER_DOWN] & ~ot_s & ~latch_off_r; // R5 R10 R11
	wire [2:0] a_card = card_lvl(w[pcsw_pkg::BIT_A_HIGH_RAIL],
	                             w[pcsw_pkg::BIT_A_LOW_RAIL], rail5_s); // R3
	wire [2:0] b_card = card_lvl(w[pcsw_pkg::BIT_B_HIGH_RAIL],
	                             w[pcsw_pkg::BIT_B_LOW_RAIL], rail5_s); // R4
	wire [2:0] a_prog = prog_lvl(w[pcsw_pkg::BIT_A_PROG_HI],
	                             w[pcsw_pkg::BIT_A_PROG_LO], a_card, rail5_s); // R1
	wire [2:0] b_prog = prog_lvl(w[pcsw_pkg::BIT_B_PROG_HI],
	                             w[pcsw_pkg::BIT_B_PROG_LO], b_card, rail5_s); // R2
	wire [2:0] lvl_nxt [4];
	assign lvl_nxt[pcsw_pkg::SUP_A_CARD] = run_ok ? a_card : pcsw_pkg::LVL_FLOAT;
	assign lvl_nxt[pcsw_pkg::SUP_A_PROG] = run_ok ? a_prog : pcsw_pkg::LVL_FLOAT;
	assign lvl_nxt[pcsw_pkg::SUP_B_CARD] = run_ok ? b_card : pcsw_pkg::LVL_FLOAT;
	assign lvl_nxt[pcsw_pkg::SUP_B_PROG] = run_ok ? b_prog : pcsw_pkg::LVL_FLOAT;

	// Sensor synchroniser: all flags are asynchronous analog comparators
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			sen_s1_r <= 10'h000;
			sen_s2_r <= 10'h000;
		end else begin
			sen_s1_r <= {RAIL_5V_PRESENT_IN, BELOW_GROUND_IN, OVERTEMP_IN, OVERCURRENT_IN};
			sen_s2_r <= sen_s1_r;
		end
	end

	// Per-supply level and limit; limiting keeps the level, only that output
	genvar g;
	generate
		for (g = 0; g < pcsw_pkg::NUM_SUP; g++) begin : g_sup
			always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
				if (!RST_B_IN) begin
					lvl_r[g]   <= pcsw_pkg::LVL_FLOAT;
					limit_r[g] <= 1'b0;
				end else begin
					lvl_r[g]   <= lvl_nxt[g]; // R9
					limit_r[g] <= ovc_s[g] & (lvl_nxt[g] != pcsw_pkg::LVL_FLOAT); // R8
				end
			end
		end
	endgenerate

	// Flags; latch-off leaves only through RST_B_IN, the power cycle
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			latch_off_r <= 1'b0;
			ovc_n_r     <= 1'b1;
			low_pwr_r   <= 1'b1;
			ot_d_r      <= 1'b0;
			ovc_d_r     <= 1'b0;
		end else begin
			latch_off_r <= latch_off_r | (|bg_s); // R11
			ovc_n_r     <= ~(|ovc_s); // R7
			low_pwr_r   <= ~w[pcsw_pkg::BIT_POWER_DOWN]; // R5
			ot_d_r      <= ot_s;
			ovc_d_r     <= |ovc_s;
		end
	end

	// APB decode; no wait state, read data is registered in the setup cycle so it comes from a flip-flop
	wire setup   = PSEL_IN & ~PENABLE_IN;
	wire wr_go   = PSEL_IN & PENABLE_IN & pready_r & PWRITE_IN;
	wire hit_ctl = PADDR_IN == pcsw_pkg::OFF_CTRL;
	wire hit_wrd = PADDR_IN == pcsw_pkg::OFF_WORD;
	wire hit_sta = PADDR_IN == pcsw_pkg::OFF_STAT;
	wire hit_ist = PADDR_IN == pcsw_pkg::OFF_IRQ_STS;
	wire hit_icl = PADDR_IN == pcsw_pkg::OFF_IRQ_CLR;
	wire hit_ien = PADDR_IN == pcsw_pkg::OFF_IRQ_EN;
	wire hit_any = hit_ctl | hit_wrd | hit_sta | hit_ist | hit_icl | hit_ien;
	wire [7:0] stat_v = {rail5_s, low_pwr_r, latch_off_r, ot_s, ovc_s};
	wire [31:0] rd_mux = hit_ctl ? {31'h0, ctrl_r} :
	                     hit_wrd ? {23'h0, w} :
	                     hit_sta ? {24'h0, stat_v} :
	                     hit_ist ? {28'h0, irq_sts_r} :
	                     hit_ien ? {28'h0, irq_en_r} : 32'h0;

	// Events and sticky status; a new event beats a same-cycle clear
	wire [3:0] ev = {~latch_off_r & (|bg_s), ot_s & ~ot_d_r,
	                 (|ovc_s) & ~ovc_d_r, link.word_stb};
	wire [3:0] clr = (wr_go && hit_icl) ? PWDATA_IN[3:0] : 4'h0;
	wire [3:0] sts_nxt = (irq_sts_r & ~clr) | ev;

	// Bus answer registered in the setup cycle
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup & ~hit_any;
			prdata_r  <= setup ? rd_mux : 32'h0;
		end
	end

	// Writable registers and interrupt line
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ctrl_r    <= pcsw_pkg::CTRL_RESET;
			irq_en_r  <= pcsw_pkg::IRQ_EN_RESET;
			irq_sts_r <= 4'h0;
			irq_r     <= 1'b0;
		end else begin
			if (wr_go && hit_ctl) begin
				ctrl_r <= PWDATA_IN[pcsw_pkg::CTRL_LINK_EN];
			end
			if (wr_go && hit_ien) begin
				irq_en_r <= PWDATA_IN[3:0];
			end
			irq_sts_r <= sts_nxt;
			irq_r     <= |(irq_sts_r & irq_en_r);
		end
	end

	assign SLOT_A_CARD_SUPPLY_OUT = lvl_r[pcsw_pkg::SUP_A_CARD];
	assign SLOT_A_PROG_SUPPLY_OUT = lvl_r[pcsw_pkg::SUP_A_PROG];
	assign SLOT_B_CARD_SUPPLY_OUT = lvl_r[pcsw_pkg::SUP_B_CARD];
	assign SLOT_B_PROG_SUPPLY_OUT = lvl_r[pcsw_pkg::SUP_B_PROG];
	assign CURRENT_LIMIT_OUT      = limit_r;
	assign OVERCURRENT_FLAG_N_OUT = ovc_n_r;
	assign LOW_POWER_OUT          = low_pwr_r;
	assign IRQ_OUT                = irq_r;
	assign PRDATA_OUT             = prdata_r;
	assign PREADY_OUT             = pready_r;
	assign PSLVERR_OUT            = pslverr_r;

	// Checks
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RST_B_IN);

	wire live = w[pcsw_pkg::BIT_POWER_DOWN] & ~ot_s & ~latch_off_r;
	wire all_float = (lvl_r[0] == pcsw_pkg::LVL_FLOAT) && (lvl_r[1] == pcsw_pkg::LVL_FLOAT)
	              && (lvl_r[2] == pcsw_pkg::LVL_FLOAT) && (lvl_r[3] == pcsw_pkg::LVL_FLOAT);
	sequence s_bg_seen;
		|bg_s;
	endsequence
	sequence s_stay_off;
		latch_off_r [*8] ##0 all_float;
	endsequence

	property p_power_down;
		!w[pcsw_pkg::BIT_POWER_DOWN] |=> all_float && LOW_POWER_OUT;
	endproperty
	a_power_down: assert property (p_power_down) else $error("power-down did not float"); // R5
	property p_a_prog_12v;
		live && rail5_s && w[1:0] == 2'b01 |=> SLOT_A_PROG_SUPPLY_OUT == pcsw_pkg::LVL_12V;
	endproperty
	a_a_prog_12v: assert property (p_a_prog_12v) else $error("slot A prog not 12 V"); // R1
	property p_b_prog_follow;
		live && w[5:4] == 2'b10 |=> SLOT_B_PROG_SUPPLY_OUT == SLOT_B_CARD_SUPPLY_OUT;
	endproperty
	a_b_prog_follow: assert property (p_b_prog_follow) else $error("slot B prog not following"); // R2
	property p_a_card_3v3;
		live && w[3:2] == 2'b01 |=> SLOT_A_CARD_SUPPLY_OUT == pcsw_pkg::LVL_3V3;
	endproperty
	a_a_card_3v3: assert property (p_a_card_3v3) else $error("slot A card not 3.3 V"); // R3
	property p_b_card_5v;
		live && rail5_s && w[7:6] == 2'b01 |=> SLOT_B_CARD_SUPPLY_OUT == pcsw_pkg::LVL_5V;
	endproperty
	a_b_card_5v: assert property (p_b_card_5v) else $error("slot B card not 5 V"); // R4
	property p_a_follow;
		live && w[1:0] == 2'b10 |=> SLOT_A_PROG_SUPPLY_OUT == SLOT_A_CARD_SUPPLY_OUT;
	endproperty
	a_a_follow: assert property (p_a_follow) else $error("slot A prog not following"); // R6
	property p_ovc_flag;
		(|OVERCURRENT_IN) ##1 (|OVERCURRENT_IN) ##1 (|OVERCURRENT_IN) |=> !OVERCURRENT_FLAG_N_OUT;
	endproperty
	a_ovc_flag: assert property (p_ovc_flag) else $error("overcurrent flag stayed high"); // R7
	property p_limit_local;
		ovc_s == 4'h1 && live |=> CURRENT_LIMIT_OUT[3:1] == 3'h0;
	endproperty
	a_limit_local: assert property (p_limit_local) else $error("limit spread to other outputs"); // R8
	property p_limit_keeps;
		ovc_s[0] && live && w[3:2] == 2'b01 |=> SLOT_A_CARD_SUPPLY_OUT == pcsw_pkg::LVL_3V3;
	endproperty
	a_limit_keeps: assert property (p_limit_keeps) else $error("overcurrent switched output off"); // R9
	property p_overtemp;
		ot_s |=> all_float;
	endproperty
	a_overtemp: assert property (p_overtemp) else $error("over-temperature left output on"); // R10
	property p_latch_off;
		s_bg_seen |=> ##1 s_stay_off;
	endproperty
	a_latch_off: assert property (p_latch_off) else $error("latch-off released early"); // R11
	property p_low_volt;
		!rail5_s |=> SLOT_A_CARD_SUPPLY_OUT != pcsw_pkg::LVL_5V
		         && SLOT_A_PROG_SUPPLY_OUT != pcsw_pkg::LVL_12V
		         && SLOT_B_PROG_SUPPLY_OUT != pcsw_pkg::LVL_12V;
	endproperty
	a_low_volt: assert property (p_low_volt) else $error("5 V or 12 V without 5 V input"); // R13
endmodule : pcsw_top

// [verif/pcsw_ctl_model.sv]
// Card interface controller model that shifts control words over the serial link
`timescale 1ns/10ps
module pcsw_ctl_model (
	output logic link_clock_out,  // Serial clock, still outside frames
	output logic link_data_out,   // Serial data, first bit is D8
	output logic link_latch_out   // Latch strobe after the shift
);
	// Idle levels
	initial begin
		link_clock_out = 1'b0;
		link_data_out  = 1'b0;
		link_latch_out = 1'b0;
	end

	// Shift the low nbits of w, most significant first, then latch if asked
	task automatic send_word(input logic [8:0] w, input int nbits, input logic latch);
		for (int i = nbits - 1; i >= 0; i--) begin
			link_data_out <= w[i];
			#62.5 link_clock_out = 1'b1;
			#62.5 link_clock_out = 1'b0;
		end
		// Latch only after the whole frame has gone out
		if (latch) begin
			#62.5 link_latch_out = 1'b1;
			#62.5 link_latch_out = 1'b0;
		end
		// Data not repeated after the frame, so a late sample cannot pass by luck
		link_data_out = ~link_data_out;
	endtask : send_word
endmodule : pcsw_ctl_model

// [verif/tb.sv]
// Self-checking testbench of the card power switch control block
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, lerr;
	logic        lclk, ldata, llatch, otemp, rail5, flag_n, lowp, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  ovc, bg, lim;
	logic [2:0]  ac, ap, bc, bp;
	logic [8:0]  w;
	int          fails, num_checks;

	// Reference clock, 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	pcsw_top i_dut (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .LINK_CLOCK_IN(lclk),
		.LINK_DATA_IN(ldata), .LINK_LATCH_IN(llatch), .OVERCURRENT_IN(ovc),
		.OVERTEMP_IN(otemp), .BELOW_GROUND_IN(bg), .RAIL_5V_PRESENT_IN(rail5),
		.SLOT_A_CARD_SUPPLY_OUT(ac), .SLOT_A_PROG_SUPPLY_OUT(ap),
		.SLOT_B_CARD_SUPPLY_OUT(bc), .SLOT_B_PROG_SUPPLY_OUT(bp), .CURRENT_LIMIT_OUT(lim),
		.OVERCURRENT_FLAG_N_OUT(flag_n), .LOW_POWER_OUT(lowp), .IRQ_OUT(irq));
	pcsw_ctl_model i_ctl (.link_clock_out(lclk), .link_data_out(ldata),
		.link_latch_out(llatch));

	// Card supply level from its (first, second) bit pair
	function automatic logic [2:0] card(input logic h, input logic l, input logic r5);
		if ({h, l} == 2'h1) return pcsw_pkg::LVL_3V3;
		if ({h, l} == 2'h2) return r5 ? pcsw_pkg::LVL_5V : pcsw_pkg::LVL_FLOAT;
		return pcsw_pkg::LVL_GND;
	endfunction : card

	// Programming supply level; follow copies the card level
	function automatic logic [2:0] prog(input logic p, input logic f, input logic [2:0] c,
		input logic r5);
		if ({p, f} == 2'h0) return pcsw_pkg::LVL_GND;
		if ({p, f} == 2'h1) return c;
		if ({p, f} == 2'h2) return r5 ? pcsw_pkg::LVL_12V : pcsw_pkg::LVL_FLOAT;
		return pcsw_pkg::LVL_FLOAT;
	endfunction : prog

	// Expected {b prog, b card, a prog, a card}
	function automatic logic [11:0] exp_lv(input logic [8:0] v, input logic r5);
		logic [2:0] a, b;
		a = card(v[3], v[2], r5);
		b = card(v[6], v[7], r5);
		if (!v[8]) return {4{pcsw_pkg::LVL_FLOAT}};
		return {prog(v[4], v[5], b, r5), b, prog(v[0], v[1], a, r5), a};
	endfunction : exp_lv

	// One APB transfer; waits for pready as long as it takes, the watchdog ends a hang
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd   = prdata;
		lerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Compare supply levels and low-power state against the word
	task automatic chk_out(input logic [8:0] v);
		`CHK({bp, bc, ap, ac}, exp_lv(v, rail5))
		`CHK(lowp, ~v[8])
	endtask : chk_out

	// Send and latch a whole word, then let it settle
	task automatic put(input logic [8:0] v);
		i_ctl.send_word(v, 9, 1'b1);
		repeat (12) @(posedge clk);
	endtask : put

	// Verdict and end of run
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	// Watchdog, well beyond the expected run length
	initial begin
		#800000;
		fails++;
		complete_run();
	end

	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{ovc, bg, otemp, rst_b} = '0;
		rail5 = 1'b1;
		fails = 0;
		num_checks = 0;
		void'($urandom(1));
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK({bp, bc, ap, ac, lim, flag_n, lowp, irq}, 19'h00006)
		apb(0, pcsw_pkg::OFF_CTRL, 0);
		`CHK(rd, 32'h00000001)
		apb(0, pcsw_pkg::OFF_IRQ_EN, 0);
		`CHK(rd, 32'h00000000)
		apb(0, 8'h18, 0);
		`CHK({lerr, rd}, 33'h100000000)
		$display("reset and register map done");

		// Corner codes in every pair first, random words after
		for (int k = 0; k < 40; k++) begin
			w = (k < 8) ? {1'b1, {4{k[1:0]}}} : 9'($urandom);
			rail5 <= (k < 8) ? ~k[2] : 1'($urandom);
			if (k >= 8) w[8] = ($urandom % 4) != 0;
			put(w);
			chk_out(w);
			apb(0, pcsw_pkg::OFF_WORD, 0);
			`CHK(rd, {23'h0, w})
		end
		rail5 <= 1'b1;
		$display("decode done");

		// Unlatched frames and refused latches leave the outputs alone
		w = 9'h1a5;
		put(w);
		i_ctl.send_word(9'h0f0, 9, 1'b0);
		repeat (12) @(posedge clk);
		chk_out(w);
		apb(1, pcsw_pkg::OFF_CTRL, 0);
		put(9'h155);
		chk_out(w);
		apb(1, pcsw_pkg::OFF_CTRL, 1);
		i_ctl.send_word(9'h0, 0, 1'b1);
		repeat (12) @(posedge clk);
		chk_out(9'h155);
		apb(1, pcsw_pkg::OFF_WORD, 0);
		apb(0, pcsw_pkg::OFF_WORD, 0);
		`CHK(rd, 32'h00000155)
		$display("latching done");

		// Overcurrent on each output in turn, with interrupt raise, mask, clear
		w = 9'h156;
		put(w);
		apb(1, pcsw_pkg::OFF_IRQ_CLR, 32'hf);
		for (int i = 0; i < 4; i++) begin
			apb(1, pcsw_pkg::OFF_IRQ_EN, 32'h2);
			ovc <= 4'h1 << i;
			repeat (8) @(posedge clk);
			`CHK(lim, 4'h1 << i)
			`CHK(flag_n, 1'b0)
			chk_out(w);
			`CHK(irq, 1'b1)
			apb(1, pcsw_pkg::OFF_IRQ_EN, 0);
			repeat (4) @(posedge clk);
			`CHK(irq, 1'b0)
			ovc <= 4'h0;
			repeat (8) @(posedge clk);
			`CHK({flag_n, lim}, 5'h10)
			apb(0, pcsw_pkg::OFF_IRQ_STS, 0);
			`CHK(rd[pcsw_pkg::EV_OVC], 1'b1)
			apb(1, pcsw_pkg::OFF_IRQ_CLR, 32'hf);
			apb(0, pcsw_pkg::OFF_IRQ_STS, 0);
			`CHK(rd[3:0], 4'h0)
		end
		$display("overcurrent done");

		// Over-temperature floats everything until it clears
		apb(1, pcsw_pkg::OFF_IRQ_EN, 32'h4);
		otemp <= 1'b1;
		repeat (8) @(posedge clk);
		`CHK({bp, bc, ap, ac, irq}, 13'h0001)
		otemp <= 1'b0;
		repeat (8) @(posedge clk);
		chk_out(w);
		$display("overtemp done");

		// Below-ground latches off until a reset
		bg <= 4'h2;
		repeat (8) @(posedge clk);
		bg <= 4'h0;
		put(w);
		`CHK({bp, bc, ap, ac}, 12'h000)
		apb(0, pcsw_pkg::OFF_STAT, 0);
		`CHK(rd[pcsw_pkg::STAT_LATCHOFF], 1'b1)
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		put(w);
		chk_out(w);
		$display("latch-off done");
		complete_run();
	end
endmodule : tb
